/* File: common/fsp_pkg.sv */
// Purpose: Shared constants and types for the flash status and configuration block
// Assumes: One command at a time arrives already decoded from the serial front end
// Notes: Status bit positions and the register write time are house choices

package fsp_pkg;

   // Status byte layout
   localparam int ST_BUSY = 0;
   localparam int ST_UNLOCK = 1;
   localparam int ST_GUARD_LO = 2;
   localparam int ST_GUARD_HI = 4;
   localparam int ST_WIPE_FAIL = 5;
   localparam int ST_PROG_FAIL = 6;
   localparam int ST_LOCK = 7;

   // Configuration byte layout
   localparam int CF_FREEZE = 0;
   localparam int CF_QUAD = 1;
   localparam int CF_PARAM_TOP = 2;
   localparam int CF_VOLATILE = 3;
   localparam int CF_GUARD_DIR = 5;
   localparam logic [7:0] CF_USED_MASK = 8'h2F;
   localparam logic [7:0] CF_FACTORY = 8'h00;

   // Block guard values
   localparam logic [2:0] GUARD_NONE = 3'h0;
   localparam logic [2:0] GUARD_ALL = 3'h7;
   localparam int SECTOR_COUNT = 64;
   localparam int SECTOR_LSB = 16;
   localparam int ADDR_W = 22;

   // Serial framing
   localparam logic [2:0] BITS_PER_BYTE_MASK = 3'h7;

   // Register write duration
   localparam int REG_WRITE_CYCLES = 64;

   typedef enum logic [3:0] {
      FSP_CMD_NONE,
      FSP_CMD_UNLOCK,
      FSP_CMD_LOCK,
      FSP_CMD_REG_WRITE,
      FSP_CMD_PAGE_WRITE,
      FSP_CMD_QUAD_PAGE_WRITE,
      FSP_CMD_OTP_WRITE,
      FSP_CMD_WIPE64,
      FSP_CMD_WIPE4K,
      FSP_CMD_WIPE8K,
      FSP_CMD_WIPE_ALL,
      FSP_CMD_LOWEST_POWER,
      FSP_CMD_POWER_WAKE
   } fsp_cmd_code_t;

   typedef struct packed {
      fsp_cmd_code_t code;
      logic [ADDR_W-1:0] addr;
      logic [7:0] status_data;
      logic [7:0] config_data;
      logic config_present;
   } fsp_cmd_t;

   typedef struct packed {
      logic is_erase;
      fsp_cmd_code_t code;
      logic [ADDR_W-1:0] addr;
   } fsp_array_req_t;

   typedef enum logic [1:0] {
      FSP_PWR_STANDBY,
      FSP_PWR_ACTIVE,
      FSP_PWR_DEEP
   } fsp_power_t;

endpackage : fsp_pkg

/* File: core/fsp_core.sv */
// Purpose: Status, configuration and protection logic of a serial NOR flash
// Assumes: Decoded commands come on clk; serial pins are asynchronous and synchronised here
// Notes: Nonvolatile bits live in the array; they are loaded after reset and written back

module fsp_core #(
   parameter int REG_WRITE_CYCLES = fsp_pkg::REG_WRITE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial pins
   input wire logic sck,
   input wire logic chip_enable_n,
   input wire logic write_guard_pin,
   input wire logic halt_pin,
   // Decoded command from the serial front end
   input wire logic cmd_valid,
   input wire fsp_pkg::fsp_cmd_t cmd,
   // Array engine
   output fsp_pkg::fsp_array_req_t arr_req,
   output logic arr_start,
   input wire logic arr_done,
   input wire logic arr_fail,
   // Nonvolatile store
   input wire logic [7:0] nv_status_in,
   input wire logic [7:0] nv_config_in,
   output logic nv_write,
   output logic [7:0] nv_status_out,
   output logic [7:0] nv_config_out,
   // Register views and pin roles
   output logic [7:0] status_reg,
   output logic [7:0] flash_config,
   output logic hard_guard_mode,
   output logic guard_pin_active,
   output logic pause_pin_active,
   output logic lanes_quad,
   output fsp_pkg::fsp_power_t power_state
);

   typedef enum logic [1:0] {
      FSP_IDLE,
      FSP_REG_BUSY,
      FSP_ARR_BUSY
   } fsp_state_t;

   fsp_state_t state;
   logic [2:0] sck_sync;
   logic [2:0] cs_sync;
   logic [1:0] wp_sync;
   logic [1:0] hold_sync;
   logic [2:0] pulse_count;
   logic cmd_pending;
   fsp_pkg::fsp_cmd_t cmd_held;
   logic load_pending;
   logic unlock_latch;
   logic status_lock_bit;
   logic [2:0] block_guard_field;
   logic prog_fail;
   logic wipe_fail;
   logic guard_lock_bit;
   logic four_lane_io_bit;
   logic param_region_top_bit;
   logic guard_volatility_bit;
   logic guard_direction_bit;
   logic deep_power;
   logic [$clog2(REG_WRITE_CYCLES+1)-1:0] reg_timer;

   logic sck_rise;
   logic cs_rise;
   logic cs_fall;
   logic selected;
   logic guard_pin_low;
   logic framed_ok;
   logic execute;
   logic is_modify;
   logic is_array;
   logic is_erase;
   logic addr_guarded;
   logic array_go;
   logic reg_go;
   logic reg_allowed;
   logic [6:0] guard_span;
   logic [5:0] sector;
   logic [7:0] new_cfg;

   // Two flip-flops before any logic; a third stage only for edge finding
   always_ff @(posedge clk) begin
      if (rst) begin
         sck_sync <= 3'h0;
         cs_sync <= 3'h7;
         wp_sync <= 2'h3;
         hold_sync <= 2'h3;
      end else begin
         sck_sync <= {sck_sync[1:0], sck};
         cs_sync <= {cs_sync[1:0], chip_enable_n};
         wp_sync <= {wp_sync[0], write_guard_pin};
         hold_sync <= {hold_sync[0], halt_pin};
      end
   end

   assign sck_rise = sck_sync[1] && !sck_sync[2];
   assign cs_rise = cs_sync[1] && !cs_sync[2];
   assign cs_fall = !cs_sync[1] && cs_sync[2];
   assign selected = !cs_sync[1];
   // In quad mode the pins carry data, so their guard and pause roles vanish
   assign guard_pin_low = !wp_sync[1] && !four_lane_io_bit;
   assign lanes_quad = four_lane_io_bit;
   assign guard_pin_active = !four_lane_io_bit;
   assign pause_pin_active = !four_lane_io_bit;

   // Clock pulses within one selection, counted modulo eight
   always_ff @(posedge clk) begin
      if (rst) begin
         pulse_count <= 3'h0;
      end else if (cs_fall) begin
         pulse_count <= 3'h0;
      end else if (selected && sck_rise && (hold_sync[1] || four_lane_io_bit)) begin
         pulse_count <= pulse_count + 3'h1;
      end
   end

   assign framed_ok = (pulse_count & fsp_pkg::BITS_PER_BYTE_MASK) == 3'h0;

   // Command waits for deselect, where the frame length is known
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_pending <= 1'b0;
         cmd_held <= '0;
      end else if (cmd_valid && state == FSP_IDLE) begin
         cmd_pending <= 1'b1;
         cmd_held <= cmd;
      end else if (cs_rise) begin
         cmd_pending <= 1'b0;
      end
   end

   assign execute = cmd_pending && cs_rise && state == FSP_IDLE;

   always_comb begin
      is_array = 1'b0;
      is_erase = 1'b0;
      case (cmd_held.code)
         fsp_pkg::FSP_CMD_PAGE_WRITE,
         fsp_pkg::FSP_CMD_QUAD_PAGE_WRITE,
         fsp_pkg::FSP_CMD_OTP_WRITE: begin
            is_array = 1'b1;
         end
         fsp_pkg::FSP_CMD_WIPE64,
         fsp_pkg::FSP_CMD_WIPE4K,
         fsp_pkg::FSP_CMD_WIPE8K,
         fsp_pkg::FSP_CMD_WIPE_ALL: begin
            is_array = 1'b1;
            is_erase = 1'b1;
         end
         default: begin
            is_array = 1'b0;
            is_erase = 1'b0;
         end
      endcase
   end

   assign is_modify = is_array || cmd_held.code == fsp_pkg::FSP_CMD_REG_WRITE;

   // Guarded span in 64 KB sectors: 0, 1, 2, 4 .. 32, then all 64
   always_comb begin
      if (block_guard_field == fsp_pkg::GUARD_NONE) begin
         guard_span = 7'h00;
      end else if (block_guard_field == fsp_pkg::GUARD_ALL) begin
         guard_span = 7'(fsp_pkg::SECTOR_COUNT);
      end else begin
         guard_span = 7'h01 << (block_guard_field - 3'h1);
      end
   end

   assign sector = cmd_held.addr[fsp_pkg::ADDR_W-1:fsp_pkg::SECTOR_LSB];

   // Reads are never checked here; only program and erase see the guard, and OTP write is exempt
   always_comb begin
      if (cmd_held.code == fsp_pkg::FSP_CMD_OTP_WRITE) begin
         addr_guarded = 1'b0;
      end else if (cmd_held.code == fsp_pkg::FSP_CMD_WIPE_ALL) begin
         addr_guarded = guard_span != 7'h00;
      end else if (guard_direction_bit) begin
         addr_guarded = {1'b0, sector} < guard_span;
      end else begin
         addr_guarded = {1'b0, sector} >= (7'(fsp_pkg::SECTOR_COUNT) - guard_span);
      end
   end

   // A write is refused whole when it would touch anything locked
   always_comb begin
      new_cfg = cmd_held.config_present ? (cmd_held.config_data & fsp_pkg::CF_USED_MASK)
                                        : flash_config;
      reg_allowed = 1'b1;
      if (hard_guard_mode &&
          (cmd_held.status_data[fsp_pkg::ST_LOCK] != status_lock_bit ||
           cmd_held.status_data[fsp_pkg::ST_GUARD_HI:fsp_pkg::ST_GUARD_LO] != block_guard_field)) begin
         reg_allowed = 1'b0;
      end
      if (guard_lock_bit &&
          (cmd_held.status_data[fsp_pkg::ST_GUARD_HI:fsp_pkg::ST_GUARD_LO] != block_guard_field ||
           new_cfg[fsp_pkg::CF_GUARD_DIR] != guard_direction_bit ||
           new_cfg[fsp_pkg::CF_PARAM_TOP] != param_region_top_bit ||
           !new_cfg[fsp_pkg::CF_FREEZE])) begin
         reg_allowed = 1'b0;
      end
      if ((param_region_top_bit && !new_cfg[fsp_pkg::CF_PARAM_TOP]) ||
          (guard_volatility_bit && !new_cfg[fsp_pkg::CF_VOLATILE]) ||
          (guard_direction_bit && !new_cfg[fsp_pkg::CF_GUARD_DIR])) begin
         reg_allowed = 1'b0;
      end
   end

   assign array_go = execute && is_array && unlock_latch && framed_ok && !deep_power
                     && !addr_guarded;
   assign reg_go = execute && cmd_held.code == fsp_pkg::FSP_CMD_REG_WRITE && unlock_latch
                   && framed_ok && !deep_power && reg_allowed;

   // Operation sequencing
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= FSP_IDLE;
         reg_timer <= '0;
      end else begin
         case (state)
            FSP_IDLE: begin
               if (array_go) begin
                  state <= FSP_ARR_BUSY;
               end else if (reg_go) begin
                  state <= FSP_REG_BUSY;
                  reg_timer <= ($bits(reg_timer))'(REG_WRITE_CYCLES - 1);
               end
            end
            FSP_REG_BUSY: begin
               if (reg_timer == '0) begin
                  state <= FSP_IDLE;
               end else begin
                  reg_timer <= reg_timer - 1'b1;
               end
            end
            FSP_ARR_BUSY: begin
               if (arr_done) begin
                  state <= FSP_IDLE;
               end
            end
            default: begin
               state <= FSP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         arr_start <= 1'b0;
         arr_req <= '0;
      end else begin
         arr_start <= array_go;
         if (array_go) begin
            arr_req <= '{is_erase: is_erase, code: cmd_held.code, addr: cmd_held.addr};
         end
      end
   end

   // Unlock latch; cleared once a modifying command has run its course
   always_ff @(posedge clk) begin
      if (rst) begin
         unlock_latch <= 1'b0;
      end else if (execute && cmd_held.code == fsp_pkg::FSP_CMD_UNLOCK) begin
         unlock_latch <= 1'b1;
      end else if (execute && cmd_held.code == fsp_pkg::FSP_CMD_LOCK) begin
         unlock_latch <= 1'b0;
      end else if ((state == FSP_ARR_BUSY && arr_done) ||
                   (state == FSP_REG_BUSY && reg_timer == '0)) begin
         unlock_latch <= 1'b0;
      end
   end

   // Failure flags describe only the most recent array operation; register writes leave them alone
   always_ff @(posedge clk) begin
      if (rst) begin
         prog_fail <= 1'b0;
         wipe_fail <= 1'b0;
      end else if (array_go) begin
         prog_fail <= 1'b0;
         wipe_fail <= 1'b0;
      end else if (state == FSP_ARR_BUSY && arr_done) begin
         prog_fail <= arr_fail && !arr_req.is_erase;
         wipe_fail <= arr_fail && arr_req.is_erase;
      end
   end

   // Deep power-down: leaves only on the wake command
   always_ff @(posedge clk) begin
      if (rst) begin
         deep_power <= 1'b0;
      end else if (execute && cmd_held.code == fsp_pkg::FSP_CMD_LOWEST_POWER && framed_ok) begin
         deep_power <= 1'b1;
      end else if (execute && cmd_held.code == fsp_pkg::FSP_CMD_POWER_WAKE) begin
         deep_power <= 1'b0;
      end
   end

   // Nonvolatile bits are fetched one cycle after reset, since a reset may load constants only
   always_ff @(posedge clk) begin
      if (rst) begin
         load_pending <= 1'b1;
      end else begin
         load_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_lock_bit <= 1'b0;
         block_guard_field <= fsp_pkg::GUARD_NONE;
      end else if (load_pending) begin
         status_lock_bit <= nv_status_in[fsp_pkg::ST_LOCK];
         block_guard_field <= nv_config_in[fsp_pkg::CF_VOLATILE] ? fsp_pkg::GUARD_ALL
                              : nv_status_in[fsp_pkg::ST_GUARD_HI:fsp_pkg::ST_GUARD_LO];
      end else if (reg_go) begin
         status_lock_bit <= cmd_held.status_data[fsp_pkg::ST_LOCK];
         block_guard_field <= cmd_held.status_data[fsp_pkg::ST_GUARD_HI:fsp_pkg::ST_GUARD_LO];
      end
   end

   // Freeze is volatile, so only a power-on reset can clear it
   always_ff @(posedge clk) begin
      if (rst) begin
         guard_lock_bit <= fsp_pkg::CF_FACTORY[fsp_pkg::CF_FREEZE];
         four_lane_io_bit <= fsp_pkg::CF_FACTORY[fsp_pkg::CF_QUAD];
         param_region_top_bit <= fsp_pkg::CF_FACTORY[fsp_pkg::CF_PARAM_TOP];
         guard_volatility_bit <= fsp_pkg::CF_FACTORY[fsp_pkg::CF_VOLATILE];
         guard_direction_bit <= fsp_pkg::CF_FACTORY[fsp_pkg::CF_GUARD_DIR];
      end else if (load_pending) begin
         four_lane_io_bit <= nv_config_in[fsp_pkg::CF_QUAD];
         param_region_top_bit <= nv_config_in[fsp_pkg::CF_PARAM_TOP];
         guard_volatility_bit <= nv_config_in[fsp_pkg::CF_VOLATILE];
         guard_direction_bit <= nv_config_in[fsp_pkg::CF_GUARD_DIR];
      end else if (reg_go) begin
         guard_lock_bit <= new_cfg[fsp_pkg::CF_FREEZE];
         four_lane_io_bit <= new_cfg[fsp_pkg::CF_QUAD];
         param_region_top_bit <= new_cfg[fsp_pkg::CF_PARAM_TOP];
         guard_volatility_bit <= new_cfg[fsp_pkg::CF_VOLATILE];
         guard_direction_bit <= new_cfg[fsp_pkg::CF_GUARD_DIR];
      end
   end

   // Write-back of the nonvolatile image at the end of a register write
   always_ff @(posedge clk) begin
      if (rst) begin
         nv_write <= 1'b0;
         nv_status_out <= 8'h00;
         nv_config_out <= 8'h00;
      end else begin
         nv_write <= state == FSP_REG_BUSY && reg_timer == '0;
         if (state == FSP_REG_BUSY && reg_timer == '0) begin
            nv_status_out <= {status_lock_bit, 2'h0, block_guard_field, 2'h0};
            nv_config_out <= flash_config & ~(8'h01 << fsp_pkg::CF_FREEZE);
         end
      end
   end

   always_comb begin
      status_reg = 8'h00;
      status_reg[fsp_pkg::ST_BUSY] = state != FSP_IDLE;
      status_reg[fsp_pkg::ST_UNLOCK] = unlock_latch;
      status_reg[fsp_pkg::ST_GUARD_HI:fsp_pkg::ST_GUARD_LO] = block_guard_field;
      status_reg[fsp_pkg::ST_WIPE_FAIL] = wipe_fail;
      status_reg[fsp_pkg::ST_PROG_FAIL] = prog_fail;
      status_reg[fsp_pkg::ST_LOCK] = status_lock_bit;
   end

   always_comb begin
      flash_config = 8'h00;
      flash_config[fsp_pkg::CF_FREEZE] = guard_lock_bit;
      flash_config[fsp_pkg::CF_QUAD] = four_lane_io_bit;
      flash_config[fsp_pkg::CF_PARAM_TOP] = param_region_top_bit;
      flash_config[fsp_pkg::CF_VOLATILE] = guard_volatility_bit;
      flash_config[fsp_pkg::CF_GUARD_DIR] = guard_direction_bit;
   end

   assign hard_guard_mode = status_lock_bit && guard_pin_low;

   // Deselect does not drop to standby while an operation still runs
   always_comb begin
      if (deep_power && state == FSP_IDLE) begin
         power_state = fsp_pkg::FSP_PWR_DEEP;
      end else if (selected || state != FSP_IDLE) begin
         power_state = fsp_pkg::FSP_PWR_ACTIVE;
      end else begin
         power_state = fsp_pkg::FSP_PWR_STANDBY;
      end
   end

endmodule : fsp_core

/* File: testbench/fsp_checker.sv */
// Purpose: Concurrent checks on the status, configuration and guard ports
// Assumes: One clock domain with synchronous active-high reset
// Notes: Flag updates are allowed one spare cycle after the causing edge
module fsp_checker #(
   parameter int REG_WRITE_CYCLES = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Array engine
   input wire logic arr_start,
   input wire logic arr_done,
   input wire logic arr_fail,
   input wire fsp_pkg::fsp_array_req_t arr_req,
   // Register views and pin roles
   input wire logic [7:0] status_reg,
   input wire logic [7:0] flash_config,
   input wire logic hard_guard_mode,
   input wire logic guard_pin_active,
   input wire logic pause_pin_active,
   input wire logic lanes_quad
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_op_end;
      arr_done && status_reg[fsp_pkg::ST_BUSY];
   endsequence
   sequence s_idle_locked;
      !status_reg[fsp_pkg::ST_BUSY] && !status_reg[fsp_pkg::ST_UNLOCK];
   endsequence

   property p_start_busy; arr_start |-> status_reg[fsp_pkg::ST_BUSY]; endproperty
   a_start_busy: assert property (p_start_busy) else $error("start without busy");
   property p_op_end; s_op_end |-> ##[1:2] s_idle_locked; endproperty
   a_op_end: assert property (p_op_end) else $error("busy or latch kept");
   property p_fail_set;
      s_op_end ##0 arr_fail |-> ##[1:2] status_reg[arr_req.is_erase ? 5 : 6];
   endproperty
   a_fail_set: assert property (p_fail_set) else $error("fail flag missing");
   property p_fail_clear; arr_start |-> ##[0:1] status_reg[6:5] == 2'h0; endproperty
   a_fail_clear: assert property (p_fail_clear) else $error("stale fail flag");
   property p_hard; hard_guard_mode |-> status_reg[fsp_pkg::ST_LOCK] && !lanes_quad; endproperty
   a_hard: assert property (p_hard) else $error("hard mode without cause");
   property p_quad;
      lanes_quad == flash_config[fsp_pkg::CF_QUAD] && guard_pin_active == !lanes_quad
         && pause_pin_active == !lanes_quad;
   endproperty
   a_quad: assert property (p_quad) else $error("pin roles wrong");
   property p_one_way; ($past(flash_config) & 8'h2D & ~flash_config) == 8'h00; endproperty
   a_one_way: assert property (p_one_way) else $error("one-way bit cleared");
   property p_frozen;
      flash_config[0] && $past(flash_config[0]) |-> $stable(status_reg[4:2])
         && $stable(flash_config[5]) && $stable(flash_config[2]);
   endproperty
   a_frozen: assert property (p_frozen) else $error("frozen field changed");
endmodule : fsp_checker

bind fsp_core fsp_checker #(.REG_WRITE_CYCLES(REG_WRITE_CYCLES)) i_fsp_checker (.clk, .rst,
   .arr_start, .arr_done, .arr_fail, .arr_req, .status_reg, .flash_config, .hard_guard_mode,
   .guard_pin_active, .pause_pin_active, .lanes_quad);

/* File: testbench/fsp_host_model.sv */
// Purpose: Host model sending select frames and decoded commands
// Assumes: Link clock period of 80 ns, 20 core cycles
// Notes: Link clock stands low outside frames
module fsp_host_model (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic sck,
   output logic chip_enable_n,
   // Decoded command
   output logic cmd_valid,
   output fsp_pkg::fsp_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sck = 1'b0;
      chip_enable_n = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
   end

   task automatic send(input fsp_pkg::fsp_cmd_t c, input int n);
      @(posedge clk);
      chip_enable_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (10) @(posedge clk);
         sck <= 1'b1;
         repeat (10) @(posedge clk);
         sck <= 1'b0;
      end
      cmd <= c;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      // Stale command bits are inverted so nothing can lean on them
      cmd <= ~c;
      repeat (4) @(posedge clk);
      chip_enable_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : send
endmodule : fsp_host_model

/* File: testbench/fsp_core_tb.sv */
// Purpose: Self-checking bench for the flash status and guard core
// Assumes: Bench plays the array engine and the nonvolatile store
// Notes: Register write time cut to 4 cycles
module fsp_core_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rst, write_guard_pin, sck, chip_enable_n, cmd_valid, arr_start, arr_done;
   logic arr_fail, nv_write, hard_guard_mode, guard_pin_active, pause_pin_active, lanes_quad;
   logic halt_pin;
   logic [7:0] nv_cfg, status_reg, flash_config;
   fsp_pkg::fsp_cmd_t cmd;
   fsp_pkg::fsp_array_req_t arr_req;
   fsp_pkg::fsp_power_t power_state;
   int num_errors = 0;
   int tests_run = 0;
   int starts = 0;

   fsp_core #(.REG_WRITE_CYCLES(4)) i_fsp_core (.clk, .rst, .sck, .chip_enable_n,
      .write_guard_pin, .halt_pin, .cmd_valid, .cmd, .arr_req, .arr_start, .arr_done,
      .arr_fail, .nv_status_in(8'h00), .nv_config_in(nv_cfg), .nv_write, .nv_status_out(),
      .nv_config_out(), .status_reg, .flash_config, .hard_guard_mode, .guard_pin_active,
      .pause_pin_active, .lanes_quad, .power_state);
   fsp_host_model i_fsp_host_model (.clk, .sck, .chip_enable_n, .cmd_valid, .cmd);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (arr_start === 1'b1) begin
         starts <= starts + 1;
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic do_reset();
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : do_reset

   task automatic frame(input fsp_pkg::fsp_cmd_code_t code, input logic [21:0] a,
                        input logic [7:0] sd, input logic [7:0] cd, input int n);
      i_fsp_host_model.send('{code, a, sd, cd, 1'b1}, n);
   endtask : frame

   task automatic go(input fsp_pkg::fsp_cmd_code_t code, input logic [21:0] a);
      frame(code, a, 8'h00, 8'h00, 8);
   endtask : go

   task automatic op(input fsp_pkg::fsp_cmd_code_t code, input logic [21:0] a);
      go(fsp_pkg::FSP_CMD_UNLOCK, 22'h0);
      go(code, a);
   endtask : op

   task automatic regw(input logic [7:0] sd, input logic [7:0] cd);
      int n;
      go(fsp_pkg::FSP_CMD_UNLOCK, 22'h0);
      frame(fsp_pkg::FSP_CMD_REG_WRITE, 22'h0, sd, cd, 8);
      n = 0;
      while (status_reg[0] !== 1'b0 && n < 500) begin
         @(posedge clk);
         n++;
      end
      if (n >= 500) begin
         num_errors++;
         finish_test();
      end
   endtask : regw

   task automatic arr(input fsp_pkg::fsp_cmd_code_t code, input logic [21:0] a, input bit ok,
                      input bit fail);
      int s0;
      s0 = starts;
      op(code, a);
      chk("array start", starts - s0, ok);
      if (ok) begin
         chk("busy", status_reg[0], 1'b1);
         chk("active", power_state, fsp_pkg::FSP_PWR_ACTIVE);
         chk("req addr", arr_req.addr, a);
         arr_done <= 1'b1;
         arr_fail <= fail;
         @(posedge clk);
         arr_done <= 1'b0;
         repeat (3) @(posedge clk);
         chk("op end", status_reg[1:0], 2'b00);
         chk("standby", power_state, fsp_pkg::FSP_PWR_STANDBY);
      end
   endtask : arr

   task automatic t_program();
      fsp_pkg::fsp_cmd_code_t codes[5];
      codes = '{fsp_pkg::FSP_CMD_QUAD_PAGE_WRITE, fsp_pkg::FSP_CMD_OTP_WRITE,
         fsp_pkg::FSP_CMD_WIPE64, fsp_pkg::FSP_CMD_WIPE8K, fsp_pkg::FSP_CMD_WIPE_ALL};
      go(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h001000);
      chk("no latch", status_reg[1:0], 2'b00);
      go(fsp_pkg::FSP_CMD_UNLOCK, 22'h0);
      chk("latch", status_reg[1], 1'b1);
      frame(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h001000, 8'h00, 8'h00, 12);
      chk("odd count", status_reg[1:0], 2'b10);
      // Paused clock pulses are not counted, so a twelve-pulse frame still runs
      halt_pin <= 1'b0;
      frame(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h001000, 8'h00, 8'h00, 12);
      chk("paused count", status_reg[0], 1'b1);
      halt_pin <= 1'b1;
      arr_done <= 1'b1;
      @(posedge clk);
      arr_done <= 1'b0;
      repeat (3) @(posedge clk);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h001000, 1, 1);
      chk("prog fail", status_reg[6:5], 2'b10);
      arr(fsp_pkg::FSP_CMD_WIPE4K, 22'h002000, 1, 1);
      chk("wipe fail", status_reg[6:5], 2'b01);
      foreach (codes[i]) begin
         arr(codes[i], 22'h003000, 1, 0);
      end
      chk("no fail", status_reg[6:5], 2'b00);
      op(fsp_pkg::FSP_CMD_LOCK, 22'h0);
      chk("lock cmd", status_reg[1], 1'b0);
   endtask : t_program

   task automatic t_guard();
      regw(8'h04, 8'h00);
      chk("guard", status_reg[4:2], 3'h1);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h3F0000, 0, 0);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h3EFFFF, 1, 0);
      arr(fsp_pkg::FSP_CMD_WIPE_ALL, 22'h000000, 0, 0);
      regw(8'h18, 8'h00);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h200000, 0, 0);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h1FFFFF, 1, 0);
      regw(8'h1C, 8'h00);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h000000, 0, 0);
      // Parameter sectors top, guard bottom, bit 4 clear
      regw(8'h04, 8'h24);
      chk("cfg", flash_config, 8'h24);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h00FFFF, 0, 0);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h010000, 1, 0);
      regw(8'h04, 8'h00);
      chk("one way", flash_config, 8'h24);
      regw(8'h04, 8'h2D);
      chk("freeze", flash_config, 8'h2D);
      regw(8'h08, 8'h2D);
      chk("frozen", status_reg[4:2], 3'h1);
      nv_cfg <= 8'h08;
      do_reset();
      chk("por", flash_config, 8'h08);
      chk("volatile", status_reg[4:2], 3'h7);
      nv_cfg <= 8'h00;
      do_reset();
   endtask : t_guard

   task automatic t_pins();
      regw(8'h80, 8'h00);
      write_guard_pin <= 1'b0;
      repeat (5) @(posedge clk);
      chk("hard mode", hard_guard_mode, 1'b1);
      regw(8'h84, 8'h00);
      chk("read only", status_reg[7:2], 6'h20);
      write_guard_pin <= 1'b1;
      regw(8'h80, 8'h02);
      chk("quad pins", {lanes_quad, guard_pin_active, pause_pin_active}, 3'b100);
      write_guard_pin <= 1'b0;
      repeat (5) @(posedge clk);
      chk("no hard", hard_guard_mode, 1'b0);
      do_reset();
   endtask : t_pins

   task automatic t_deep();
      go(fsp_pkg::FSP_CMD_LOWEST_POWER, 22'h0);
      chk("deep", power_state, fsp_pkg::FSP_PWR_DEEP);
      arr(fsp_pkg::FSP_CMD_PAGE_WRITE, 22'h001000, 0, 0);
      chk("still deep", power_state, fsp_pkg::FSP_PWR_DEEP);
      go(fsp_pkg::FSP_CMD_POWER_WAKE, 22'h0);
      chk("wake", power_state, fsp_pkg::FSP_PWR_STANDBY);
   endtask : t_deep

   initial begin
      rst = 1'b1;
      write_guard_pin = 1'b1;
      halt_pin = 1'b1;
      arr_done = 1'b0;
      arr_fail = 1'b0;
      nv_cfg = 8'h00;
      do_reset();
      chk("factory", flash_config, 8'h00);
      chk("status", status_reg, 8'h00);
      t_program();
      t_guard();
      t_pins();
      t_deep();
      finish_test();
   end
endmodule : fsp_core_tb
